// *** shared/ssw_pkg.sv ***
// Function
// - Undervoltage drives high reset high and low reset low.
// - After supply recovers, hold both resets for the 200 ms timeout.
// - Write-lock high refuses every memory write, contents unchanged.
// - Write-lock low or open allows writes to the whole array.
// - Manual push input low asserts the reset outputs.
// - Reset held while push input low, plus full timeout after release.
// - Push input is debounced so short disturbances start no reset.
// - Open push input reads high through a pull-up; no reset.
// - Externally forced active-low reset pin starts a reset; its timeout runs from the start of the force.
// - Writes blocked below threshold, also during power-up.
// - Reduced variant: low output only, writes gated by undervoltage.
package ssw_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned TIMEOUT_MS = 200;
	localparam longint unsigned TIMEOUT_CYC =
		(longint'(TIMEOUT_MS) * 64'd1000000000) / CLK_PERIOD_PS;
	localparam int unsigned DEBOUNCE_NS = 100;
	localparam int unsigned DEBOUNCE_CYC =
		(DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CNT_W = 26;
	localparam int unsigned DB_W = 6;
	localparam logic [CNT_W-1:0] CNT_RST = 26'h0;
	localparam logic [DB_W-1:0] DB_RST = 6'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SSW_ST_HOLD = 2'b01,
		SSW_ST_RUN = 2'b10
	} ssw_state_t;

	typedef struct packed {
		logic uv;
		logic push;
		logic pin;
	} ssw_src_t;
endpackage : ssw_pkg

// *** logic/ssw_supervisor.sv ***
`timescale 1ns/1ps
module ssw_supervisor import ssw_pkg::*; #(
	parameter bit FULL_VARIANT = 1'b1,
	parameter longint unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Supervision inputs
	input wire logic i_undervolt,
	input wire logic i_push_n,
	input wire logic i_write_lock,
	// Active-low open-drain reset pin
	input wire logic i_rst_pin_n,
	output logic o_rst_pin_n,
	output logic o_rst_pin_oe,
	// Active-high reset output
	output logic o_rst_hi,
	output logic o_rst_hi_oe,
	// Memory write gate
	input wire logic i_wr_req,
	output logic o_wr_en
);
	// ----------------------------------------------------------------
	// Sources
	// ----------------------------------------------------------------
	logic [DB_W-1:0] db_cnt_q, db_cnt_d;
	logic push_q, push_d;
	logic rst_q, rst_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	ssw_state_t st_q, st_d;
	logic wr_en_q, wr_en_d;
	logic hi_oe_q, hi_oe_d;
	ssw_src_t src;
	wire logic any_src;
	wire logic pin_forced;
	wire logic push_raw;
	wire logic db_done;
	wire logic cnt_done;
	wire logic lock_eff;

	// The pin reads low while we drive it ourselves, so only a low seen
	// while released counts as an outside force.
	assign pin_forced = !i_rst_pin_n && !rst_q;
	assign push_raw = !i_push_n;
	assign db_done = (db_cnt_q == DB_W'(DEBOUNCE_CYC - 1));
	// Level must be stable over the filter window before it is taken.
	assign db_cnt_d = (push_raw == push_q) ? DB_RST :
		(db_done ? DB_RST : db_cnt_q + 6'h1);
	assign push_d = (push_raw != push_q && db_done) ? push_raw : push_q;

	always_comb begin
		src.uv = i_undervolt;
		src.push = push_q;
		src.pin = pin_forced;
	end
	assign any_src = |src;

	// ----------------------------------------------------------------
	// Timeout sequencer
	// ----------------------------------------------------------------
	assign cnt_done = (cnt_q == CNT_W'(TIMEOUT_CYCLES - 1));

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		rst_d = rst_q;
		case (st_q)
			SSW_ST_HOLD: begin
				rst_d = 1'b1;
				cnt_d = CNT_RST;
				if (!any_src) begin
					st_d = SSW_ST_RUN;
				end
			end
			SSW_ST_RUN: begin
				rst_d = 1'b1;
				if (any_src) begin
					st_d = SSW_ST_HOLD;
					cnt_d = CNT_RST;
				end else if (cnt_done) begin
					st_d = SSW_ST_RUN;
					rst_d = 1'b0;
					cnt_d = cnt_q;
				end else if (rst_q) begin
					cnt_d = cnt_q + 26'h1;
				end
				if (!rst_q && !any_src) begin
					rst_d = 1'b0;
				end
			end
			default: begin
				st_d = SSW_ST_HOLD;
				rst_d = 1'b1;
				cnt_d = CNT_RST;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Write gate
	// ----------------------------------------------------------------
	assign lock_eff = FULL_VARIANT ? i_write_lock : 1'b0;
	assign wr_en_d = i_wr_req && !i_undervolt && !lock_eff;

	// ----------------------------------------------------------------
	// Output drive
	// ----------------------------------------------------------------
	// The high output enable gets its own flip-flop so that both pins
	// switch on the same edge and no gate sits behind either of them.
	assign hi_oe_d = FULL_VARIANT ? rst_d : 1'b0;

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	// While the enable is low every register keeps its value, so the
	// timeout simply stretches by the frozen cycles.
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= SSW_ST_HOLD;
			cnt_q <= CNT_RST;
			rst_q <= 1'b1;
			db_cnt_q <= DB_RST;
			push_q <= 1'b0;
			wr_en_q <= 1'b0;
			hi_oe_q <= FULL_VARIANT;
		end else if (i_ce) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			rst_q <= rst_d;
			db_cnt_q <= db_cnt_d;
			push_q <= push_d;
			wr_en_q <= wr_en_d;
			hi_oe_q <= hi_oe_d;
		end
	end

	// Open drain: the low pin drives only low, the high pin only high; the other level is left to the pull resistor.
	assign o_rst_pin_n = 1'b0;
	assign o_rst_pin_oe = rst_q;
	assign o_rst_hi = 1'b1;
	assign o_rst_hi_oe = hi_oe_q;
	assign o_wr_en = wr_en_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	uv_asserts_a: assert property (
		i_ce && i_undervolt |=> o_rst_pin_oe)
		else $error("undervoltage did not assert reset");
	pair_match_a: assert property (
		FULL_VARIANT |-> o_rst_hi_oe == o_rst_pin_oe)
		else $error("reset outputs disagree");
	hold_timeout_a: assert property (
		i_ce && any_src |=> cnt_q == CNT_RST)
		else $error("timeout not restarted by a source");
	release_done_a: assert property (
		$fell(rst_q) |-> $past(cnt_done))
		else $error("reset released before timeout");
	ce_freeze_a: assert property (
		!i_ce |=> $stable(cnt_q) && $stable(rst_q))
		else $error("state moved while enable low");
	push_holds_a: assert property (
		i_ce && push_q |=> rst_q)
		else $error("reset not held while push low");
	push_release_a: assert property (
		$fell(rst_q) |-> !$past(push_q))
		else $error("reset released while push low");
	lock_blocks_a: assert property (
		i_ce && FULL_VARIANT && i_write_lock |=> !o_wr_en)
		else $error("write passed while locked");
	uv_blocks_a: assert property (
		i_ce && i_undervolt |=> !o_wr_en)
		else $error("write passed during undervoltage");
	free_write_a: assert property (
		i_ce && i_wr_req && !i_undervolt && !i_write_lock |=> o_wr_en)
		else $error("allowed write was blocked");
	glitch_reject_a: assert property (
		i_ce && !push_q && $rose(push_raw) |=> !push_q)
		else $error("push glitch taken at once");
	pin_force_a: assert property (
		i_ce && pin_forced |=> st_q == SSW_ST_HOLD)
		else $error("forced pin did not hold reset");
	variant_hi_a: assert property (
		!FULL_VARIANT |-> !o_rst_hi_oe)
		else $error("reduced variant drove high output");

	cov_release_c: cover property ($fell(rst_q));
	cov_push_c: cover property ($rose(push_q));
	cov_restart_c: cover property (st_q == SSW_ST_RUN && cnt_q != CNT_RST
		&& any_src);
	cov_pin_c: cover property (pin_forced);
endmodule : ssw_supervisor

// *** testbench/ssw_host_mcu.sv ***
`timescale 1ns/1ps
module ssw_host_mcu (
	input wire logic i_pin_oe,
	input wire logic i_pin_val,
	input wire logic i_hi_oe,
	input wire logic i_hi_val,
	input wire logic i_force,
	output logic o_wire_n,
	output logic o_rst_hi
);
	// The low wire has a pull-up, so only a driver or a force pulls it.
	assign o_wire_n = !((i_pin_oe && !i_pin_val) || i_force);
	// The high wire has a pull-down and floats low when released.
	assign o_rst_hi = i_hi_oe && i_hi_val;
endmodule : ssw_host_mcu

// *** testbench/tb_supply_supervisor_write_guard.sv ***
`timescale 1ns/1ps
module tb_supply_supervisor_write_guard;
	import ssw_pkg::*;
	localparam int T = 20;
	logic clk = 0, rst_n = 0, uv = 0, push_n = 1, lock = 0, frc = 0;
	logic req = 0, pin_oe, pin_v, hi_oe, hi_v, wire_n, hi, wr_en, e;
	logic ce = 1;
	int n_mismatch = 0, checked = 0, seed = 7152;
	initial forever #2 clk = ~clk;
	ssw_supervisor #(.TIMEOUT_CYCLES(T)) i_dut (.i_clk_sys(clk),
		.i_rst_n(rst_n), .i_ce(ce), .i_undervolt(uv), .i_push_n(push_n),
		.i_write_lock(lock), .i_rst_pin_n(wire_n), .o_rst_pin_n(pin_v),
		.o_rst_pin_oe(pin_oe), .o_rst_hi(hi_v), .o_rst_hi_oe(hi_oe),
		.i_wr_req(req), .o_wr_en(wr_en));
	ssw_host_mcu i_mcu (.i_pin_oe(pin_oe), .i_pin_val(pin_v),
		.i_hi_oe(hi_oe), .i_hi_val(hi_v), .i_force(frc),
		.o_wire_n(wire_n), .o_rst_hi(hi));
	task chk(input logic s, input logic x);
		checked++;
		if (s !== x) begin
			n_mismatch++;
			$display("CHECK FAILED %0t saw %b want %b", $time, s, x);
		end
	endtask : chk
	task w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	// Both wires are checked together, as the host sees them.
	task rs(input logic x);
		chk(wire_n, !x);
		chk(hi, x);
	endtask : rs
	task give_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	initial begin
		#20000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		w(16);
		rs(1);
		rst_n = 1;
		w(T + 4);
		rs(0);
		for (int i = 0; i < 8; i++) begin
			req = $random(seed);
			lock = $random(seed);
			e = req & !lock;
			w(1);
			chk(wr_en, e);
		end
		req = 1;
		lock = 0;
		uv = 1;
		w(2);
		rs(1);
		chk(wr_en, 1'b0);
		uv = 0;
		w(T - 1);
		rs(1);
		w(4);
		rs(0);
		chk(wr_en, 1'b1);
		push_n = 0;
		w(10);
		push_n = 1;
		w(3);
		rs(0);
		push_n = 0;
		w(30);
		rs(1);
		push_n = 1;
		w(T);
		rs(1);
		w(T + 30);
		rs(0);
		frc = 1;
		w(3);
		frc = 0;
		w(T - 5);
		rs(1);
		w(T);
		rs(0);
		uv = 1;
		w(2);
		uv = 0;
		w(10);
		uv = 1;
		w(2);
		uv = 0;
		w(T - 3);
		rs(1);
		w(8);
		rs(0);
		uv = 1;
		w(2);
		uv = 0;
		ce = 0;
		w(10);
		ce = 1;
		w(T - 3);
		rs(1);
		w(15);
		rs(0);
		give_verdict();
	end
endmodule : tb_supply_supervisor_write_guard
